// File: dv/nss_scanner.sv
/*
  poll master model: sends one-cycle poll requests with a setpoint.
  assumes the bench calls poll() and the node answers by itself.
*/
`timescale 1ns/1ns
`default_nettype none
module nss_scanner (
  input  wire logic  clk_i,
  output logic       poll_req_o,
  output logic [3:0] poll_len_o,
  output logic [15:0] poll_setpoint_o
);
  initial begin
    poll_req_o      = 1'b0;
    poll_len_o      = 4'h0;
    poll_setpoint_o = 16'h0000;
  end
  // request with setpoint, lines inverted once released
  task automatic poll(input logic [3:0] len, input logic [15:0] sp);
    @(posedge clk_i);
    poll_req_o      <= 1'b1;
    poll_len_o      <= len;
    poll_setpoint_o <= sp;
    @(posedge clk_i);
    poll_req_o      <= 1'b0;
    poll_len_o      <= ~len;
    poll_setpoint_o <= ~sp;
  endtask
endmodule // nss_scanner
`default_nettype wire

// File: dv/tb_top.sv
/*
  self-checking bench of the status supervisor.
  assumes a short indicator phase and zero-wait APB.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
  import nss_pkg::*;
  localparam int unsigned PH = 8;
  logic           clk, rst, psel, pen, pwr, pready, perr, er;
  logic           st_ok, peer, net_ok, conn, preq, accept, loop_en, vclose, rvalid, irq;
  logic [11:0]    paddr;
  logic [31:0]    pwdata, prdata, rd;
  logic [3:0]     plen;
  logic [15:0]    psp, press, prev_press, sp_out, sp;
  logic [15:0]    sp_q[$];
  logic [6:0]     sw_addr;
  logic [1:0]     sw_rate, rate;
  logic [5:0]     naddr, exp_addr;
  logic [7:0]     dstate;
  nss_led_s       mod_led, net_led;
  nss_poll_resp_s resp;
  int             errors, cmp_count, nr, ng, no;

  nss_supervisor #(.PHASE_CYC(PH)) nss_supervisor_i (
    .clk_sys_i(clk), .sys_rst_i(rst), .paddr_i(paddr), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(perr), .self_test_pass_i(st_ok),
    .peer_seen_i(peer), .net_ok_i(net_ok), .conn_active_i(conn),
    .poll_req_i(preq), .poll_len_i(plen), .poll_setpoint_i(psp),
    .pressure_i(press), .node_addr_sw_i(sw_addr), .rate_sw_i(sw_rate),
    .mod_led_o(mod_led), .net_led_o(net_led), .conn_accept_o(accept),
    .dev_state_o(dstate), .ctrl_loop_en_o(loop_en), .valve_close_o(vclose),
    .setpoint_o(sp_out), .poll_resp_valid_o(rvalid), .poll_resp_o(resp),
    .node_addr_o(naddr), .bit_rate_o(rate), .irq_o(irq));
  nss_scanner nss_scanner_i (.clk_i(clk), .poll_req_o(preq), .poll_len_o(plen),
    .poll_setpoint_o(psp));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    prev_press <= press;
    press      <= 16'($urandom);
  end
  always @(negedge clk) begin
    if (!rst) begin
      `CHK(mod_led.red & mod_led.green, 1'b0)
      `CHK(net_led.red & net_led.green, 1'b0)
    end
  end

  task automatic give_verdict();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    pen    <= 1'b0;
    paddr  <= a;
    pwr    <= w;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      errors++;
      give_verdict();
    end
    rd = prdata;
    er = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
    @(negedge clk);
  endtask
  task automatic count_leds(input int cyc, input logic network_status_indicator);
    nss_led_s l;
    nr = 0;
    ng = 0;
    no = 0;
    repeat (cyc) begin
      @(negedge clk);
      l = network_status_indicator ? net_led : mod_led;
      if (l.red) nr++;
      else if (l.green) ng++;
      else no++;
    end
  endtask

  initial begin
    {rst, psel, pen, pwr, st_ok, peer, net_ok, conn} = 8'h80;
    {paddr, pwdata, press, prev_press} = '0;
    sw_rate = 2'h1;
    void'($urandom(32'h3a2fb275));
    sw_addr = 7'($urandom_range(63));
    exp_addr = sw_addr[5:0];
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(negedge clk);
    `CHK({mod_led, net_led}, 4'b1010)
    repeat (PH) @(negedge clk);
    `CHK({mod_led, net_led}, 4'b0101)
    repeat (PH + 1) @(negedge clk);
    count_leds(2 * PH, 1'b0);
    `CHK(nr > 0 && ng > 0, 1'b1)
    count_leds(PH, 1'b1);
    `CHK(no, PH)
    @(posedge clk) st_ok <= 1'b1;
    repeat (4) @(negedge clk);
    count_leds(10, 1'b0);
    `CHK(ng, 10)
    @(posedge clk) {peer, net_ok} <= 2'b11;
    repeat (4) @(negedge clk);
    count_leds(3 * PH, 1'b1);
    `CHK(ng > 0 && no > 0 && nr == 0, 1'b1)
    `CHK(accept, 1'b1)
    @(posedge clk) conn <= 1'b1;
    repeat (4) @(negedge clk);
    count_leds(10, 1'b1);
    `CHK(ng, 10)
    apb(REG_SAFE_SEL, 1'b0, '0);
    `CHK(rd, 32'h0000_1100)
    apb(REG_ASSY, 1'b0, '0);
    `CHK(rd, 32'h0000_0702)
    for (int i = 0; i < NUM_CH; i++) begin
      apb(12'(REG_CH_BASE + 4 * i), 1'b0, '0);
      `CHK(rd, 32'h1001_00C3)
    end
    apb(REG_STATUS, 1'b0, '0);
    `CHK({rd[7:0], dstate, vclose, loop_en}, 18'h0080A)
    apb(REG_NODE_CFG, 1'b0, '0);
    `CHK(rd, 32'h023F_0100 | 32'(exp_addr))
    @(posedge clk) sw_addr <= sw_addr ^ 7'h01;
    apb(REG_NODE_CFG, 1'b1, 32'h0105_0000);
    `CHK({naddr, rate}, {exp_addr, 2'h1})
    apb(REG_IRQ_STAT, 1'b0, '0);
    `CHK({rd[3:0], irq}, 5'b0110_0)
    apb(REG_IRQ_MASK, 1'b1, 32'h0000_000F);
    `CHK(irq, 1'b1)
    apb(REG_IRQ_STAT, 1'b1, 32'h0000_0006);
    apb(REG_IRQ_STAT, 1'b0, '0);
    `CHK({rd[3:0], irq}, 5'b0000_0)
    nss_scanner_i.poll(4'h3, 16'h1234);
    @(negedge clk);
    `CHK({rvalid, dstate}, 9'h002)
    repeat (3) begin
      sp = 16'($urandom);
      sp_q.push_back(sp);
      nss_scanner_i.poll(4'h2, sp);
      @(negedge clk);
      sp = sp_q.pop_front();
      `CHK({rvalid, resp.status[1], resp.pressure, sp_out}, {2'b11, prev_press, sp})
      `CHK({dstate, loop_en, vclose}, 10'h012)
      @(negedge clk);
      `CHK(rvalid, 1'b0)
    end
    apb(REG_IRQ_STAT, 1'b0, '0);
    `CHK({rd[3:0], irq}, 5'b1001_1)
    apb(REG_CTRL, 1'b1, 32'h0000_0002);
    `CHK({dstate, loop_en, vclose}, 10'h009)
    apb(REG_CTRL, 1'b1, 32'h0000_0001);
    apb(REG_STATUS, 1'b0, '0);
    `CHK({rd[7:0], dstate}, 16'h0404)
    apb(REG_SAFE_SEL, 1'b1, 32'h0000_3B05);
    apb(REG_SAFE_SEL, 1'b0, '0);
    `CHK(rd, 32'h0000_3105)
    apb(REG_CTRL, 1'b1, 32'h0000_0002);
    `CHK({dstate, loop_en, vclose}, 10'h008)
    apb(12'h400, 1'b0, '0);
    `CHK({er, rd}, 33'h0_0000_0000 | 33'h1_0000_0000)
    give_verdict();
  end
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    give_verdict();
  end
endmodule // tb_top
`undef CHK
`default_nettype wire

// File: hdl/nss_pkg.sv
/*
  constants, types and register map of the network node status supervisor.
  assumes a 10 MHz system clock and a 12-bit APB byte address.
*/
`default_nettype none
package nss_pkg;
  // timing
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned LED_PHASE_MS  = 500;
  localparam int unsigned LED_PHASE_CYC = CLK_HZ / 1000 * LED_PHASE_MS;

  // register byte offsets
  localparam logic [11:0] REG_CTRL     = 12'h000;
  localparam logic [11:0] REG_STATUS   = 12'h004;
  localparam logic [11:0] REG_IRQ_STAT = 12'h008;
  localparam logic [11:0] REG_IRQ_MASK = 12'h00C;
  localparam logic [11:0] REG_NODE_CFG = 12'h010;
  localparam logic [11:0] REG_SAFE_SEL = 12'h018;
  localparam logic [11:0] REG_ASSY     = 12'h01C;
  localparam logic [11:0] REG_CH_BASE  = 12'h020;
  localparam int unsigned NUM_CH       = 5;

  // field positions
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_STOP_BIT  = 1;
  localparam int unsigned ADDR_LSB       = 0;
  localparam int unsigned RATE_LSB       = 8;
  localparam int unsigned PEND_ADDR_LSB  = 16;
  localparam int unsigned PEND_RATE_LSB  = 24;
  localparam int unsigned SAFE_LSB       = 0;
  localparam int unsigned PAPP_LSB       = 8;
  localparam int unsigned FCAL_LSB       = 12;
  localparam int unsigned IN_ASSY_LSB    = 0;
  localparam int unsigned OUT_ASSY_LSB   = 8;
  localparam int unsigned DTYPE_LSB      = 0;
  localparam int unsigned UNITS_LSB      = 16;
  localparam int unsigned IRQ_EXEC       = 0;
  localparam int unsigned IRQ_READY      = 1;
  localparam int unsigned IRQ_CONN       = 2;
  localparam int unsigned IRQ_POLL       = 3;
  localparam int unsigned IRQ_W          = 4;

  // reset values and codes
  localparam logic [7:0]  DEV_IDLE       = 8'h02;
  localparam logic [7:0]  DEV_EXEC       = 8'h04;
  localparam logic [7:0]  DTYPE_INT      = 8'hC3;
  localparam logic [15:0] UNITS_COUNTS   = 16'h1001;
  localparam logic [7:0]  SAFE_CLOSE     = 8'h00;
  localparam logic [3:0]  SEL_DEF        = 4'h1;
  localparam logic [3:0]  SEL_MAX        = 4'hA;
  localparam logic [7:0]  IN_ASSY_DEF    = 8'h02;
  localparam logic [7:0]  OUT_ASSY_DEF   = 8'h07;
  localparam logic [3:0]  OUT_ASSY_BYTES = 4'h2;
  localparam logic [5:0]  NODE_ADDR_DEF  = 6'h3F;
  localparam logic [6:0]  NODE_ADDR_MAX  = 7'h3F;
  localparam logic [1:0]  RATE_500K      = 2'h2;
  localparam logic [1:0]  RATE_PROG      = 2'h3;

  typedef enum logic [1:0] {
    COL_OFF   = 2'b00,
    COL_RED   = 2'b01,
    COL_GREEN = 2'b10
  } nss_colour_e;

  typedef enum logic [1:0] {
    M_TEST_RED   = 2'b00,
    M_TEST_GREEN = 2'b01,
    M_SELF_TEST  = 2'b10,
    M_READY      = 2'b11
  } nss_mod_state_e;

  typedef enum logic [2:0] {
    N_TEST_RED   = 3'b000,
    N_TEST_GREEN = 3'b001,
    N_DARK       = 3'b010,
    N_FLASH      = 3'b011,
    N_STEADY     = 3'b100
  } nss_net_state_e;

  typedef struct packed {
    logic red;
    logic green;
  } nss_led_s;

  typedef struct packed {
    logic [7:0]  status;
    logic [15:0] pressure;
  } nss_poll_resp_s;
endpackage
`default_nettype wire

// File: hdl/nss_supervisor.sv
/*
  network node status supervisor: indicator sequencing, idle/executing
  state, poll answer, factory defaults and an APB register file.
  assumes all status inputs are synchronous to clk_sys_i.
*/
// The placing of the registers and the APB register port were decided locally.
// Summary of operation
// R01 - at power-up both indicators show red, then green, before anything else
// R02 - module indicator alternates red and green while self-test runs
// R03 - module indicator goes steady green when all self-tests pass
// R04 - network indicator stays dark until a peer finished duplicate address check
// R05 - network indicator flashes green and connections accepted once network recognised
// R06 - network indicator steady green while any connection is active
// R07 - every valid poll with setpoint is answered with status and pressure
// R08 - default poll assemblies are input instance 2 and output instance 7
// R09 - device state reads two when idle and four when executing
// R10 - idle holds safe mode with the control loop off
// R11 - idle goes executing on start service or first valid poll
// R12 - default data type of the five values is 16-bit signed integer
// R13 - default data units of the five values is counts
// R14 - valve safe state defaults to zero, closing valve in safe state
// R15 - application and calibration selectors pick one of ten, default one
// R16 - address and bit rate changes apply only after next power cycle; reset restores pending defaults, so written values never apply
// R17 - node address ranges 0 to 63 and defaults to 63
// R18 - each indicator is off, red or green, never red and green
`timescale 1ns/1ns
`default_nettype none
module nss_supervisor
  import nss_pkg::*;
#(
  parameter int unsigned PHASE_CYC = LED_PHASE_CYC
) (
  input  wire logic           clk_sys_i,
  input  wire logic           sys_rst_i,
  input  wire logic [11:0]    paddr_i,
  input  wire logic           psel_i,
  input  wire logic           penable_i,
  input  wire logic           pwrite_i,
  input  wire logic [31:0]    pwdata_i,
  output var  logic [31:0]    prdata_o,
  output logic                pready_o,
  output logic                pslverr_o,
  input  wire logic           self_test_pass_i,
  input  wire logic           peer_seen_i,
  input  wire logic           net_ok_i,
  input  wire logic           conn_active_i,
  input  wire logic           poll_req_i,
  input  wire logic [3:0]     poll_len_i,
  input  wire logic [15:0]    poll_setpoint_i,
  input  wire logic [15:0]    pressure_i,
  input  wire logic [6:0]     node_addr_sw_i,
  input  wire logic [1:0]     rate_sw_i,
  output var  nss_led_s       mod_led_o,
  output var  nss_led_s       net_led_o,
  output logic                conn_accept_o,
  output logic [7:0]          dev_state_o,
  output var  logic           ctrl_loop_en_o,
  output var  logic           valve_close_o,
  output var  logic [15:0]    setpoint_o,
  output var  logic           poll_resp_valid_o,
  output var  nss_poll_resp_s poll_resp_o,
  output var  logic [5:0]     node_addr_o,
  output var  logic [1:0]     bit_rate_o,
  output logic                irq_o
);

  // phase timer shared by test, blink and flash
  logic [22:0]    phase_cnt;
  logic           blink;
  wire            tick = (phase_cnt == 23'(PHASE_CYC - 1));

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      phase_cnt <= 23'h000000;
      blink     <= 1'b0;
    end else begin
      phase_cnt <= tick ? 23'h000000 : phase_cnt + 23'h000001;
      blink     <= tick ? ~blink : blink;
    end
  end

  // module status indicator sequence
  nss_mod_state_e mod_state;
  nss_mod_state_e next_mod_state;
  nss_colour_e    mod_col;

  always_comb begin
    next_mod_state = mod_state;
    case (mod_state)
      M_TEST_RED:   if (tick) next_mod_state = M_TEST_GREEN; // R01
      M_TEST_GREEN: if (tick) next_mod_state = M_SELF_TEST;  // R01
      M_SELF_TEST:  if (self_test_pass_i) next_mod_state = M_READY; // R03
      M_READY:      next_mod_state = M_READY;
      default:      next_mod_state = M_TEST_RED;
    endcase
  end

  always_comb begin
    case (mod_state)
      M_TEST_RED:   mod_col = COL_RED;
      M_TEST_GREEN: mod_col = COL_GREEN;
      M_SELF_TEST:  mod_col = blink ? COL_RED : COL_GREEN; // R02
      M_READY:      mod_col = COL_GREEN; // R03
      default:      mod_col = COL_OFF;
    endcase
  end

  // network status indicator sequence
  nss_net_state_e net_state;
  nss_net_state_e next_net_state;
  nss_colour_e    net_col;
  wire            net_seen = peer_seen_i && net_ok_i;

  always_comb begin
    next_net_state = net_state;
    case (net_state)
      N_TEST_RED:   if (tick) next_net_state = N_TEST_GREEN; // R01
      N_TEST_GREEN: if (tick) next_net_state = N_DARK;       // R01
      N_DARK:       if (net_seen) next_net_state = N_FLASH;  // R04
      N_FLASH: begin
        if (!net_seen) next_net_state = N_DARK;
        else if (conn_active_i) next_net_state = N_STEADY;   // R06
      end
      N_STEADY: begin
        if (!net_seen) next_net_state = N_DARK;
        else if (!conn_active_i) next_net_state = N_FLASH;   // R05
      end
      default:      next_net_state = N_TEST_RED;
    endcase
  end

  always_comb begin
    case (net_state)
      N_TEST_RED:   net_col = COL_RED;
      N_TEST_GREEN: net_col = COL_GREEN;
      N_FLASH:      net_col = blink ? COL_GREEN : COL_OFF; // R05
      N_STEADY:     net_col = COL_GREEN;                   // R06
      default:      net_col = COL_OFF;                     // R04
    endcase
  end

  assign conn_accept_o = (net_state == N_FLASH) || (net_state == N_STEADY); // R05

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mod_state <= M_TEST_RED;
      net_state <= N_TEST_RED;
      mod_led_o <= '0;
      net_led_o <= '0;
    end else begin
      mod_state <= next_mod_state;
      net_state <= next_net_state;
      mod_led_o <= '{red: mod_col == COL_RED, green: mod_col == COL_GREEN}; // R18
      net_led_o <= '{red: net_col == COL_RED, green: net_col == COL_GREEN}; // R18
    end
  end

  // apb decode
  wire        acc    = psel_i && penable_i;
  wire        wr     = acc && pwrite_i;
  wire        ch_hit = (paddr_i[11:5] == REG_CH_BASE[11:5]) && (paddr_i[1:0] == 2'b00)
                       && (paddr_i[4:2] < 3'(NUM_CH));
  wire [2:0]  ch_idx = paddr_i[4:2];
  wire        hit_ctrl = (paddr_i == REG_CTRL);
  wire        hit_stat = (paddr_i == REG_STATUS);
  wire        hit_istat = (paddr_i == REG_IRQ_STAT);
  wire        hit_imask = (paddr_i == REG_IRQ_MASK);
  wire        hit_node = (paddr_i == REG_NODE_CFG);
  wire        hit_safe = (paddr_i == REG_SAFE_SEL);
  wire        hit_assy = (paddr_i == REG_ASSY);
  wire        hit_any  = hit_ctrl || hit_stat || hit_istat || hit_imask || hit_node
                         || hit_safe || hit_assy || ch_hit;
  wire        start_wr = wr && hit_ctrl && pwdata_i[CTRL_START_BIT];
  wire        stop_wr  = wr && hit_ctrl && pwdata_i[CTRL_STOP_BIT];

  assign pready_o  = 1'b1;
  assign pslverr_o = acc && !hit_any;

  // idle / executing state
  logic exec;
  wire  valid_poll = poll_req_i && conn_active_i && (poll_len_i == OUT_ASSY_BYTES);
  wire  next_exec  = (start_wr || valid_poll) ? 1'b1 : (stop_wr ? 1'b0 : exec); // R11

  assign dev_state_o = exec ? DEV_EXEC : DEV_IDLE; // R09

  // configuration
  logic [7:0]  valve_safe;
  logic [3:0]  press_app;
  logic [3:0]  flow_cal;
  logic [7:0]  in_assy;
  logic [7:0]  out_assy;
  logic [5:0]  pend_addr;
  logic [1:0]  pend_rate;
  logic        cfg_latched;
  logic [7:0]  ch_dtype [NUM_CH];
  logic [15:0] ch_units [NUM_CH];
  wire  [3:0]  wr_papp = pwdata_i[PAPP_LSB +: 4];
  wire  [3:0]  wr_fcal = pwdata_i[FCAL_LSB +: 4];
  wire         papp_ok = (wr_papp != 4'h0) && (wr_papp <= SEL_MAX);
  wire         fcal_ok = (wr_fcal != 4'h0) && (wr_fcal <= SEL_MAX);
  wire  [7:0]  next_valve_safe = (wr && hit_safe) ? pwdata_i[SAFE_LSB +: 8] : valve_safe;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      valve_safe <= SAFE_CLOSE;   // R14
      press_app  <= SEL_DEF;      // R15
      flow_cal   <= SEL_DEF;      // R15
      in_assy    <= IN_ASSY_DEF;  // R08
      out_assy   <= OUT_ASSY_DEF; // R08
    end else begin
      if (wr && hit_safe) begin
        valve_safe <= next_valve_safe;
        press_app  <= papp_ok ? wr_papp : press_app; // R15
        flow_cal   <= fcal_ok ? wr_fcal : flow_cal;  // R15
      end
      if (wr && hit_assy && !conn_active_i) begin
        in_assy  <= pwdata_i[IN_ASSY_LSB +: 8];
        out_assy <= pwdata_i[OUT_ASSY_LSB +: 8];
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      wire ch_wr = wr && ch_hit && (ch_idx == 3'(gi)) && !conn_active_i;
      always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          ch_dtype[gi] <= DTYPE_INT;    // R12
          ch_units[gi] <= UNITS_COUNTS; // R13
        end else if (ch_wr) begin
          ch_dtype[gi] <= pwdata_i[DTYPE_LSB +: 8];
          ch_units[gi] <= pwdata_i[UNITS_LSB +: 16];
        end
      end
    end
  endgenerate

  // address and rate: latched once after reset from the switches or from the pending values, which reset returns to their defaults
  wire       sw_addr_ok = (node_addr_sw_i <= NODE_ADDR_MAX);
  wire [5:0] boot_addr  = sw_addr_ok ? node_addr_sw_i[5:0] : pend_addr; // R17
  wire [1:0] boot_rate  = (rate_sw_i != RATE_PROG) ? rate_sw_i : pend_rate;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pend_addr   <= NODE_ADDR_DEF; // R17
      pend_rate   <= RATE_500K;
      cfg_latched <= 1'b0;
      node_addr_o <= NODE_ADDR_DEF;
      bit_rate_o  <= RATE_500K;
    end else begin
      if (wr && hit_node) begin
        pend_addr <= pwdata_i[PEND_ADDR_LSB +: 6];
        pend_rate <= pwdata_i[PEND_RATE_LSB +: 2];
      end
      cfg_latched <= 1'b1;
      if (!cfg_latched) begin
        node_addr_o <= boot_addr; // R16
        bit_rate_o  <= boot_rate; // R16
      end
    end
  end

  // poll exchange and control outputs
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      exec              <= 1'b0;
      ctrl_loop_en_o    <= 1'b0;
      valve_close_o     <= 1'b1;
      setpoint_o        <= 16'h0000;
      poll_resp_valid_o <= 1'b0;
      poll_resp_o       <= '0;
    end else begin
      exec              <= next_exec;
      ctrl_loop_en_o    <= next_exec;                                // R10
      valve_close_o     <= !next_exec && (next_valve_safe == SAFE_CLOSE); // R14
      poll_resp_valid_o <= valid_poll;                               // R07
      if (valid_poll) begin
        setpoint_o  <= poll_setpoint_i;                              // R07
        poll_resp_o <= '{status:   {6'h00, mod_state == M_READY, next_exec},
                         pressure: pressure_i};                      // R07
      end
    end
  end

  // interrupts
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  wire  [IRQ_W-1:0] irq_ev  = {valid_poll,
                               (net_state != N_STEADY) && (next_net_state == N_STEADY),
                               (mod_state != M_READY) && (next_mod_state == M_READY),
                               !exec && next_exec};
  wire  [IRQ_W-1:0] irq_clr = (wr && hit_istat) ? pwdata_i[IRQ_W-1:0] : '0;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_stat <= '0;
      irq_mask <= '0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
      if (wr && hit_imask) irq_mask <= pwdata_i[IRQ_W-1:0];
    end
  end

  assign irq_o = |(irq_stat & irq_mask);

  // read mux, sampled in the setup cycle
  wire [31:0] rd_ch   = (ch_idx < 3'(NUM_CH)) ?
                        {ch_units[ch_idx], 8'h00, ch_dtype[ch_idx]} : 32'h00000000;
  wire [31:0] rd_node = {6'h00, pend_rate, 2'h0, pend_addr, 6'h00, bit_rate_o,
                         2'h0, node_addr_o};
  wire [31:0] rd_safe = {16'h0000, flow_cal, press_app, valve_safe};
  wire [31:0] rd_stat = {16'h0000, 1'b0, net_state, 2'b00, mod_state, dev_state_o};
  wire [31:0] rd_data = hit_stat  ? rd_stat :
                        hit_istat ? {28'h0000000, irq_stat} :
                        hit_imask ? {28'h0000000, irq_mask} :
                        hit_node  ? rd_node :
                        hit_safe  ? rd_safe :
                        hit_assy  ? {16'h0000, out_assy, in_assy} :
                        ch_hit    ? rd_ch : 32'h00000000;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) prdata_o <= 32'h00000000;
    else if (psel_i && !penable_i) prdata_o <= rd_data;
  end

  // checks
  chk_led_exclusive: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !(mod_led_o.red && mod_led_o.green) && !(net_led_o.red && net_led_o.green)) // R18
    else $error("indicator lit red and green together");

  chk_test_first: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (mod_state == M_TEST_RED) |=> mod_led_o.red || (mod_state == M_TEST_GREEN)) // R01
    else $error("indicator test not red first");

  chk_mod_ready: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (mod_state == M_SELF_TEST && self_test_pass_i) |=> ##1 mod_led_o.green
    && !mod_led_o.red) // R03
    else $error("module indicator not green after self-test");

  chk_net_dark: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (net_state == N_DARK && !net_seen) |=> ##1 !net_led_o.red && !net_led_o.green) // R04
    else $error("network indicator lit while alone");

  chk_net_steady: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (net_state == N_STEADY) [*3] |-> net_led_o.green) // R06
    else $error("network indicator not steady with connection");

  chk_state_code: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    dev_state_o == (ctrl_loop_en_o ? DEV_EXEC : DEV_IDLE)) // R09
    else $error("device state code wrong");

  chk_idle_safe: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !exec |-> !ctrl_loop_en_o && (valve_close_o == (valve_safe == SAFE_CLOSE))) // R10
    else $error("idle without safe mode");

  chk_poll_start: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (valid_poll || start_wr) |=> dev_state_o == DEV_EXEC) // R11
    else $error("start trigger did not enter executing");

  chk_poll_answer: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    valid_poll |=> poll_resp_valid_o && poll_resp_o.pressure == $past(pressure_i)
    && setpoint_o == $past(poll_setpoint_i)) // R07
    else $error("poll not answered");

  chk_addr_hold: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    cfg_latched |=> $stable(node_addr_o) && $stable(bit_rate_o)) // R16
    else $error("address changed without power cycle");

  chk_sel_range: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    press_app != 4'h0 && press_app <= SEL_MAX && flow_cal != 4'h0 && flow_cal <= SEL_MAX) // R15
    else $error("selector out of range");

endmodule // nss_supervisor
`default_nettype wire
